// *** hw/smp_pkg.sv ***
// constants, types and helpers shared by both ends of the system-bus memory port
// assumes one 200 MHz clock on both ends; bus pins are sampled as synchronous inputs
package smp_pkg;

   // bus geometry
   localparam int ADDR_W = 20;
   localparam int ADDR_HI_W = 4;
   localparam int FULL_ADDR_W = 24;
   localparam int DATA_W = 16;
   localparam int BYTE_W = 8;
   localparam int LANE_N = 2;

   // RAM window: 1024 words of 16 bits, placed by a 13-bit base over a 16 MB space
   localparam int MEM_WORD_AW = 10;
   localparam int MEM_WORDS = 1024;
   localparam int MEM_BASE_LSB = MEM_WORD_AW + 1;
   localparam int MEM_BASE_W = FULL_ADDR_W - MEM_BASE_LSB;
   // one 16-bit I/O port, selected by address bits 19..1
   localparam int IO_SEL_LSB = 1;
   localparam int IO_SEL_W = ADDR_W - IO_SEL_LSB;

   // idle (released) levels of active-low lines, and the reset value of data registers
   localparam logic [DATA_W-1:0] DATA_IDLE_N = 16'hFFFF;
   localparam logic [ADDR_W-1:0] ADDR_IDLE_N = 20'hFFFFF;
   localparam logic [ADDR_HI_W-1:0] ADDR_HI_IDLE_N = 4'hF;
   localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;

   // timing
   localparam int CLK_PERIOD_PS = 5000;
   localparam int ACK_DELAY_NS = 50;
   localparam int REFRESH_DELAY_NS = 480;
   localparam int ADDR_SETUP_NS = 50;
   localparam int CMD_SEPARATION_NS = 50;
   localparam int MST_TIMEOUT_NS = 10000;
   // least times round up, the timeout (a longest time) rounds down
   localparam int ACK_CYCLES = (ACK_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int REFRESH_CYCLES = (REFRESH_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int SETUP_CYCLES = (ADDR_SETUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int SEPARATION_CYCLES = (CMD_SEPARATION_NS * 1000 + CLK_PERIOD_PS - 1)
      / CLK_PERIOD_PS;
   localparam int TIMEOUT_CYCLES = (MST_TIMEOUT_NS * 1000) / CLK_PERIOD_PS;
   localparam int CNT_W = 12;

   typedef enum logic [1:0] {
      SMP_MEM_RD = 2'h0,
      SMP_MEM_WR = 2'h1,
      SMP_IO_RD = 2'h2,
      SMP_IO_WR = 2'h3
   } smp_cmd_type;

   typedef enum logic [1:0] {
      SMP_DEV_IDLE = 2'h0,
      SMP_DEV_ACCESS = 2'h1,
      SMP_DEV_ACK = 2'h3,
      SMP_DEV_IGNORE = 2'h2
   } smp_dev_state_type;

   typedef enum logic [1:0] {
      SMP_MST_IDLE = 2'h0,
      SMP_MST_SETUP = 2'h1,
      SMP_MST_CMD = 2'h3,
      SMP_MST_RELEASE = 2'h2
   } smp_mst_state_type;

   // odd parity over one byte: high when the byte holds an even number of ones
   function automatic logic odd_parity(input logic [BYTE_W-1:0] b);
      return ~(^b);
   endfunction

   // counter has reached a cycle figure
   function automatic logic count_done(input logic [CNT_W-1:0] cnt, input int cycles);
      return cnt == CNT_W'(cycles - 1);
   endfunction

endpackage

// *** hw/smp_bus_if.sv ***
// the system-bus wires between one master and one memory slave
// resolves the two-way data lines and the acknowledge line; released lines read high
`timescale 1ns/1ps
`default_nettype none
interface smp_bus_if;
   logic [smp_pkg::ADDR_W-1:0] adr_n;
   logic [smp_pkg::ADDR_HI_W-1:0] adr_hi_n;
   logic bhen_n;
   logic mrdc_n;
   logic mwtc_n;
   logic iorc_n;
   logic iowc_n;
   logic inh1_n;
   logic memory_protect_n;
   logic external_refresh_request_n;
   logic [smp_pkg::DATA_W-1:0] dat_mst_n;
   logic [smp_pkg::DATA_W-1:0] dat_mst_oe;
   logic [smp_pkg::DATA_W-1:0] dat_dev_n;
   logic [smp_pkg::DATA_W-1:0] dat_dev_oe;
   logic xack_dev_n;
   logic xack_dev_oe;
   logic parity_even_byte_n;
   logic parity_odd_byte_n;
   // resolved lines
   logic [smp_pkg::DATA_W-1:0] dat_n;
   logic xack_n;

   // wired-and of both data drivers with a pull-up; the acknowledge has one driver and a pull-up
   assign dat_n = (dat_dev_n | ~dat_dev_oe) & (dat_mst_n | ~dat_mst_oe);
   assign xack_n = xack_dev_n | ~xack_dev_oe;

   modport slave (
      input adr_n, adr_hi_n, bhen_n, mrdc_n, mwtc_n, iorc_n, iowc_n, inh1_n,
      input memory_protect_n, external_refresh_request_n, dat_n,
      output dat_dev_n, dat_dev_oe, xack_dev_n, xack_dev_oe,
      output parity_even_byte_n, parity_odd_byte_n
   );

   modport master (
      output adr_n, adr_hi_n, bhen_n, mrdc_n, mwtc_n, iorc_n, iowc_n, inh1_n,
      output memory_protect_n, external_refresh_request_n, dat_mst_n, dat_mst_oe,
      input dat_n, xack_n
   );
endinterface
`default_nettype wire

// *** hw/smp_refresh_sched.sv ***
// refresh scheduler of the memory slave: turns the external refresh request into
// a refresh window during which the RAM takes no access; assumes synchronous input
`timescale 1ns/1ps
`default_nettype none
module smp_refresh_sched (
   input wire logic ref_clk_i,
   input wire logic arst_n_i,
   input wire logic request_n_i,
   input wire logic idle_i,
   output logic hold_o,
   output logic busy_o
);
   logic request_q;
   logic pending;
   logic [smp_pkg::CNT_W-1:0] cnt;
   logic request_fall;
   logic start;

   assign request_fall = request_q & ~request_n_i;
   assign start = pending & idle_i & ~busy_o;
   // holding off new accesses from the request onward keeps a busy bus from starving refresh
   assign hold_o = pending | busy_o;

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         request_q <= 1'b1;
      end else begin
         request_q <= request_n_i;
      end
   end

   // a new request in the cycle of a start stays pending
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pending <= 1'b0;
      end else begin
         pending <= request_fall | (pending & ~start);
      end
   end

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         busy_o <= 1'b0;
         cnt <= '0;
      end else if (start) begin
         busy_o <= 1'b1;
         cnt <= '0;
      end else if (busy_o) begin
         if (smp_pkg::count_done(cnt, smp_pkg::REFRESH_CYCLES)) begin
            busy_o <= 1'b0;
         end
         cnt <= cnt + 1'b1;
      end
   end
endmodule
`default_nettype wire

// *** hw/smp_bus_slave.sv ***
// memory slave end of the system-bus port: 1024 x 16 RAM, one I/O port, a local port
// assumes bus pins are synchronous to ref_clk_i and the master holds a command until acked
//
// What this block does
// - 20 active-low address lines, highest line most significant
// - byte-high-enable low enables odd byte lane
// - 16 active-low data lines, low byte even
// - inhibit asserted: RAM ignores system-bus accesses
// - inhibit never blocks local port accesses
// - I/O read drives the port input io_in_i out
// - I/O write captures bus data into port
// - memory read drives addressed word out
// - memory write stores bus data into RAM
// - acknowledge only once the transfer is complete
// - memory protect asserted: ignore following commands
// - one parity output per byte when enabled
// - external refresh request schedules RAM refresh
// - upper address lines place RAM in 16 MB
`timescale 1ns/1ps
`default_nettype none
module smp_bus_slave (
   input wire logic ref_clk_i,
   input wire logic arst_n_i,
   smp_bus_if.slave bus,
   input wire logic [smp_pkg::MEM_BASE_W-1:0] mem_base_i,
   input wire logic [smp_pkg::IO_SEL_W-1:0] io_sel_i,
   input wire logic parity_enable_i,
   input wire logic [smp_pkg::DATA_W-1:0] io_in_i,
   output logic [smp_pkg::DATA_W-1:0] io_port_o,
   input wire logic loc_req_i,
   input wire logic loc_we_i,
   input wire logic [smp_pkg::MEM_WORD_AW-1:0] loc_addr_i,
   input wire logic [smp_pkg::LANE_N-1:0] loc_lanes_i,
   input wire logic [smp_pkg::DATA_W-1:0] loc_wdata_i,
   output logic loc_ack_o,
   output logic [smp_pkg::DATA_W-1:0] loc_rdata_o,
   output logic refresh_busy_o
);
   logic [smp_pkg::DATA_W-1:0] mem [0:smp_pkg::MEM_WORDS-1];

   smp_pkg::smp_dev_state_type state;
   smp_pkg::smp_dev_state_type next_state;
   logic [smp_pkg::CNT_W-1:0] cnt;
   logic is_io;
   logic is_wr;
   logic [smp_pkg::LANE_N-1:0] lanes_q;
   logic [smp_pkg::MEM_WORD_AW-1:0] word_q;
   logic [smp_pkg::DATA_W-1:0] rd_q;
   logic parity_even_q;
   logic parity_odd_q;

   logic [smp_pkg::FULL_ADDR_W-1:0] full_addr;
   logic [smp_pkg::DATA_W-1:0] bus_data;
   logic cmd_mem_rd;
   logic cmd_mem_wr;
   logic cmd_io_rd;
   logic cmd_io_wr;
   logic any_cmd;
   logic mem_hit;
   logic io_hit;
   logic [smp_pkg::LANE_N-1:0] bus_lanes;
   logic refresh_hold;
   logic start_bus;
   logic start_local;
   logic access_done;
   logic [smp_pkg::DATA_W-1:0] lane_mask;
   logic [smp_pkg::DATA_W-1:0] loc_mask;
   logic [smp_pkg::DATA_W-1:0] done_data;

   // logical view of the active-low bus
   assign full_addr = ~{bus.adr_hi_n, bus.adr_n};
   assign bus_data = ~bus.dat_n;
   assign cmd_mem_rd = ~bus.mrdc_n;
   assign cmd_mem_wr = ~bus.mwtc_n;
   assign cmd_io_rd = ~bus.iorc_n;
   assign cmd_io_wr = ~bus.iowc_n;
   assign any_cmd = cmd_mem_rd | cmd_mem_wr | cmd_io_rd | cmd_io_wr;

   // RAM answers only inside its window, when not inhibited and not protected
   assign mem_hit = (cmd_mem_rd | cmd_mem_wr)
      && (full_addr[smp_pkg::FULL_ADDR_W-1:smp_pkg::MEM_BASE_LSB] == mem_base_i)
      && bus.inh1_n
      && bus.memory_protect_n;
   assign io_hit = (cmd_io_rd | cmd_io_wr)
      && (full_addr[smp_pkg::ADDR_W-1:smp_pkg::IO_SEL_LSB] == io_sel_i)
      && bus.memory_protect_n;

   assign bus_lanes[0] = ~bus.adr_n[0];
   assign bus_lanes[1] = ~bus.bhen_n;

   // new work starts only from idle and never inside a refresh window
   assign start_bus = (state == smp_pkg::SMP_DEV_IDLE) && any_cmd && !refresh_hold;
   // the local port sees no inhibit and yields only to bus commands and refresh
   assign start_local = (state == smp_pkg::SMP_DEV_IDLE) && !any_cmd && !refresh_hold
      && loc_req_i;
   assign access_done = (state == smp_pkg::SMP_DEV_ACCESS)
      && smp_pkg::count_done(cnt, smp_pkg::ACK_CYCLES);

   assign lane_mask = {{smp_pkg::BYTE_W{lanes_q[1]}}, {smp_pkg::BYTE_W{lanes_q[0]}}};
   assign loc_mask = {{smp_pkg::BYTE_W{loc_lanes_i[1]}}, {smp_pkg::BYTE_W{loc_lanes_i[0]}}};

   // a command held off by the refresh hold must not in turn keep the refresh from starting
   smp_refresh_sched u_refresh (
      .ref_clk_i(ref_clk_i),
      .arst_n_i(arst_n_i),
      .request_n_i(bus.external_refresh_request_n),
      .idle_i(state == smp_pkg::SMP_DEV_IDLE),
      .hold_o(refresh_hold),
      .busy_o(refresh_busy_o)
   );

   always_comb begin
      next_state = state;
      case (state)
         smp_pkg::SMP_DEV_IDLE: begin
            if (start_bus) begin
               if (mem_hit || io_hit) begin
                  next_state = smp_pkg::SMP_DEV_ACCESS;
               end else begin
                  next_state = smp_pkg::SMP_DEV_IGNORE;
               end
            end
         end
         smp_pkg::SMP_DEV_ACCESS: begin
            if (access_done) begin
               next_state = smp_pkg::SMP_DEV_ACK;
            end
         end
         smp_pkg::SMP_DEV_ACK: begin
            if (!any_cmd) begin
               next_state = smp_pkg::SMP_DEV_IDLE;
            end
         end
         smp_pkg::SMP_DEV_IGNORE: begin
            if (!any_cmd) begin
               next_state = smp_pkg::SMP_DEV_IDLE;
            end
         end
         default: begin
            next_state = smp_pkg::SMP_DEV_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state <= smp_pkg::SMP_DEV_IDLE;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cnt <= '0;
      end else if (state == smp_pkg::SMP_DEV_ACCESS) begin
         cnt <= cnt + 1'b1;
      end else begin
         cnt <= '0;
      end
   end

   // the command and its address are latched at the start of the access
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         is_io <= 1'b0;
         is_wr <= 1'b0;
         lanes_q <= '0;
         word_q <= '0;
      end else if (start_bus) begin
         is_io <= cmd_io_rd | cmd_io_wr;
         is_wr <= cmd_mem_wr | cmd_io_wr;
         lanes_q <= bus_lanes;
         word_q <= full_addr[smp_pkg::MEM_WORD_AW:1];
      end
   end

   // one RAM write port, shared by bus and local side
   always_ff @(posedge ref_clk_i) begin
      if (access_done && !is_io && is_wr) begin
         mem[word_q] <= (mem[word_q] & ~lane_mask) | (bus_data & lane_mask);
      end else if (start_local && loc_we_i) begin
         mem[loc_addr_i] <= (mem[loc_addr_i] & ~loc_mask) | (loc_wdata_i & loc_mask);
      end
   end

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         io_port_o <= smp_pkg::DATA_RESET;
      end else if (access_done && is_io && is_wr) begin
         io_port_o <= (io_port_o & ~lane_mask) | (bus_data & lane_mask);
      end
   end

   // read data is captured at completion, so it is valid from the first cycle of the acknowledge
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rd_q <= smp_pkg::DATA_RESET;
      end else if (access_done && !is_wr) begin
         if (is_io) begin
            rd_q <= io_in_i;
         end else begin
            rd_q <= mem[word_q];
         end
      end
   end

   // parity follows the word of the last transfer, whichever way it went
   always_comb begin
      if (is_wr) begin
         done_data = bus_data;
      end else if (is_io) begin
         done_data = io_in_i;
      end else begin
         done_data = mem[word_q];
      end
   end

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         parity_even_q <= 1'b0;
         parity_odd_q <= 1'b0;
      end else if (!parity_enable_i) begin
         parity_even_q <= 1'b0;
         parity_odd_q <= 1'b0;
      end else if (access_done) begin
         parity_even_q <= smp_pkg::odd_parity(done_data[smp_pkg::BYTE_W-1:0]);
         parity_odd_q <= smp_pkg::odd_parity(done_data[smp_pkg::DATA_W-1:smp_pkg::BYTE_W]);
      end
   end

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         loc_ack_o <= 1'b0;
         loc_rdata_o <= smp_pkg::DATA_RESET;
      end else begin
         loc_ack_o <= start_local;
         if (start_local && !loc_we_i) begin
            loc_rdata_o <= mem[loc_addr_i];
         end
      end
   end

   // acknowledge and data pins are driven only while acknowledging an access that hit; parity pins always drive
   assign bus.xack_dev_n = ~(state == smp_pkg::SMP_DEV_ACK);
   assign bus.xack_dev_oe = (state == smp_pkg::SMP_DEV_ACK);
   assign bus.dat_dev_n = ~rd_q;
   assign bus.dat_dev_oe = (state == smp_pkg::SMP_DEV_ACK && !is_wr) ? lane_mask
      : '0;
   assign bus.parity_even_byte_n = ~parity_even_q;
   assign bus.parity_odd_byte_n = ~parity_odd_q;
endmodule
`default_nettype wire

// *** hw/smp_bus_master.sv ***
// master end of the system-bus port: runs one memory or I/O command at a time
// assumes the acknowledge and data lines are synchronous to ref_clk_i
`timescale 1ns/1ps
`default_nettype none
module smp_bus_master (
   input wire logic ref_clk_i,
   input wire logic arst_n_i,
   smp_bus_if.master bus,
   input wire logic req_i,
   input wire smp_pkg::smp_cmd_type kind_i,
   input wire logic [smp_pkg::FULL_ADDR_W-1:0] addr_i,
   input wire logic odd_byte_i,
   input wire logic [smp_pkg::DATA_W-1:0] wdata_i,
   input wire logic inhibit_i,
   input wire logic protect_i,
   input wire logic refresh_req_i,
   output logic ready_o,
   output logic done_o,
   output logic timeout_o,
   output logic [smp_pkg::DATA_W-1:0] rdata_o
);
   smp_pkg::smp_mst_state_type state;
   smp_pkg::smp_cmd_type kind_q;
   logic [smp_pkg::CNT_W-1:0] cnt;
   logic [smp_pkg::FULL_ADDR_W-1:0] addr_q;
   logic odd_q;
   logic [smp_pkg::DATA_W-1:0] wdata_q;
   logic acked;
   logic is_wr;
   logic cmd_on;

   assign ready_o = (state == smp_pkg::SMP_MST_IDLE);
   assign acked = ~bus.xack_n;
   assign is_wr = (kind_q == smp_pkg::SMP_MEM_WR) || (kind_q == smp_pkg::SMP_IO_WR);
   assign cmd_on = (state == smp_pkg::SMP_MST_CMD);

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state <= smp_pkg::SMP_MST_IDLE;
         cnt <= '0;
         timeout_o <= 1'b0;
         done_o <= 1'b0;
      end else begin
         done_o <= 1'b0;
         cnt <= cnt + 1'b1;
         case (state)
            smp_pkg::SMP_MST_IDLE: begin
               cnt <= '0;
               if (req_i) begin
                  state <= smp_pkg::SMP_MST_SETUP;
                  timeout_o <= 1'b0;
               end
            end
            smp_pkg::SMP_MST_SETUP: begin
               if (smp_pkg::count_done(cnt, smp_pkg::SETUP_CYCLES)) begin
                  state <= smp_pkg::SMP_MST_CMD;
                  cnt <= '0;
               end
            end
            smp_pkg::SMP_MST_CMD: begin
               // the command stays on until acknowledged or given up
               if (acked) begin
                  state <= smp_pkg::SMP_MST_RELEASE;
                  cnt <= '0;
               end else if (smp_pkg::count_done(cnt, smp_pkg::TIMEOUT_CYCLES)) begin
                  state <= smp_pkg::SMP_MST_RELEASE;
                  timeout_o <= 1'b1;
                  cnt <= '0;
               end
            end
            smp_pkg::SMP_MST_RELEASE: begin
               if (acked) begin
                  cnt <= '0;
               end else if (smp_pkg::count_done(cnt, smp_pkg::SEPARATION_CYCLES)) begin
                  state <= smp_pkg::SMP_MST_IDLE;
                  done_o <= 1'b1;
               end
            end
            default: begin
               state <= smp_pkg::SMP_MST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         kind_q <= smp_pkg::SMP_MEM_RD;
         addr_q <= '0;
         odd_q <= 1'b0;
         wdata_q <= smp_pkg::DATA_RESET;
      end else if (ready_o && req_i) begin
         kind_q <= kind_i;
         addr_q <= addr_i;
         odd_q <= odd_byte_i;
         wdata_q <= wdata_i;
      end
   end

   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rdata_o <= smp_pkg::DATA_RESET;
      end else if (cmd_on && acked && !is_wr) begin
         rdata_o <= ~bus.dat_n;
      end
   end

   // address and byte enable stand from setup until the end of the cycle
   assign bus.adr_n = ready_o ? smp_pkg::ADDR_IDLE_N : ~addr_q[smp_pkg::ADDR_W-1:0];
   assign bus.adr_hi_n = ready_o ? smp_pkg::ADDR_HI_IDLE_N
      : ~addr_q[smp_pkg::FULL_ADDR_W-1:smp_pkg::ADDR_W];
   assign bus.bhen_n = ready_o | ~odd_q;
   assign bus.mrdc_n = ~(cmd_on && kind_q == smp_pkg::SMP_MEM_RD);
   assign bus.mwtc_n = ~(cmd_on && kind_q == smp_pkg::SMP_MEM_WR);
   assign bus.iorc_n = ~(cmd_on && kind_q == smp_pkg::SMP_IO_RD);
   assign bus.iowc_n = ~(cmd_on && kind_q == smp_pkg::SMP_IO_WR);
   // write data is driven from setup through the command, all 16 lines
   assign bus.dat_mst_n = ~wdata_q;
   assign bus.dat_mst_oe = ((state == smp_pkg::SMP_MST_SETUP || cmd_on) && is_wr)
      ? smp_pkg::DATA_IDLE_N : '0;
   assign bus.inh1_n = ~inhibit_i;
   assign bus.memory_protect_n = ~protect_i;
   assign bus.external_refresh_request_n = ~refresh_req_i;
endmodule
`default_nettype wire

// *** test/smp_bus_sva.sv ***
// assertions on the system-bus wires between the master and the memory slave
// assumes one clock domain; instantiated beside the bus interface
`timescale 1ns/1ps
`default_nettype none
module smp_bus_sva (
   input wire logic ref_clk_i,
   input wire logic arst_n_i,
   input wire logic [19:0] adr_n,
   input wire logic bhen_n,
   input wire logic mrdc_n,
   input wire logic mwtc_n,
   input wire logic iorc_n,
   input wire logic iowc_n,
   input wire logic inh1_n,
   input wire logic memory_protect_n,
   input wire logic [15:0] dat_dev_oe,
   input wire logic xack_n
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!arst_n_i);
   wire idle = mrdc_n & mwtc_n & iorc_n & iowc_n;
   sequence s_start;
      $fell(idle);
   endsequence
   sequence s_quiet;
      xack_n && dat_dev_oe == 16'h0000;
   endsequence
   property p_release;
      idle [*3] |-> s_quiet;
   endproperty
   a_release: assert property (p_release) else $error("bus held after command");
   property p_ack_cause;
      $fell(xack_n) |-> !idle && $past(!idle, 10);
   endproperty
   a_ack_cause: assert property (p_ack_cause) else $error("ack without command");
   property p_not_early;
      s_start |-> xack_n [*8];
   endproperty
   a_not_early: assert property (p_not_early) else $error("ack too early");
   property p_inhibit;
      !inh1_n && !(mrdc_n && mwtc_n) |-> s_quiet;
   endproperty
   a_inhibit: assert property (p_inhibit) else $error("inhibited ram answered");
   property p_protect;
      !memory_protect_n && !idle |-> s_quiet;
   endproperty
   a_protect: assert property (p_protect) else $error("protected command answered");
   property p_wr_quiet;
      !(mwtc_n && iowc_n) |-> dat_dev_oe == 16'h0000;
   endproperty
   a_wr_quiet: assert property (p_wr_quiet) else $error("data driven on write");
   property p_lanes;
      !xack_n && !mrdc_n |-> dat_dev_oe == {{8{!bhen_n}}, {8{!adr_n[0]}}};
   endproperty
   a_lanes: assert property (p_lanes) else $error("wrong byte lanes");
   property p_rd_only;
      (|dat_dev_oe) |-> !$past(mrdc_n && iorc_n, 2);
   endproperty
   a_rd_only: assert property (p_rd_only) else $error("data driven outside read");
endmodule
`default_nettype wire

// *** test/system_bus_memory_slave_port_tb.sv ***
// self-checking bench: master and memory slave joined by the bus interface
// assumes the design package and interface are compiled first
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, x) begin samples_checked++; if ((g) !== (x)) begin miscompares++; \
   $display("CHECK FAILED %0t: got %h expected %h", $time, g, x); end end
`define WAIT(c, m) begin n = 0; do begin @(posedge ref_clk_i) #1; n++; end \
   while (!(c) && n < m); if (!(c)) begin miscompares++; report_and_stop(); end end
module system_bus_memory_slave_port_tb;
   logic ref_clk_i = 1'b0;
   logic arst_n_i = 1'b0;
   logic req_i, odd_byte_i, inhibit_i, protect_i, refresh_req_i, loc_req_i;
   logic loc_we_i, parity_enable_i;
   logic ready_o, done_o, timeout_o, loc_ack_o, refresh_busy_o;
   smp_pkg::smp_cmd_type kind_i;
   logic [23:0] addr_i, a;
   logic [15:0] wdata_i, rdata_o, io_in_i, io_port_o, loc_wdata_i, loc_rdata_o, w;
   logic [9:0] loc_addr_i;
   logic [16:0] mon_e;
   logic [16:0] exp_q[$];
   logic [31:0] seed = 32'h87A30B4B;
   int n, miscompares = 0, samples_checked = 0;
   always #2.5 ref_clk_i = ~ref_clk_i;
   smp_bus_if smp_bus_if_i ();
   smp_bus_slave smp_bus_slave_i (.ref_clk_i, .arst_n_i, .bus(smp_bus_if_i),
      .mem_base_i(13'h0A5), .io_sel_i(19'h00123), .parity_enable_i, .io_in_i,
      .io_port_o, .loc_req_i, .loc_we_i, .loc_addr_i, .loc_lanes_i(2'h3),
      .loc_wdata_i, .loc_ack_o, .loc_rdata_o, .refresh_busy_o);
   smp_bus_master smp_bus_master_i (.ref_clk_i, .arst_n_i, .bus(smp_bus_if_i), .req_i,
      .kind_i, .addr_i, .odd_byte_i, .wdata_i, .inhibit_i, .protect_i, .refresh_req_i,
      .ready_o, .done_o, .timeout_o, .rdata_o);
   smp_bus_sva smp_bus_sva_i (.ref_clk_i, .arst_n_i, .adr_n(smp_bus_if_i.adr_n),
      .bhen_n(smp_bus_if_i.bhen_n), .mrdc_n(smp_bus_if_i.mrdc_n),
      .mwtc_n(smp_bus_if_i.mwtc_n), .iorc_n(smp_bus_if_i.iorc_n),
      .iowc_n(smp_bus_if_i.iowc_n), .inh1_n(smp_bus_if_i.inh1_n),
      .memory_protect_n(smp_bus_if_i.memory_protect_n),
      .dat_dev_oe(smp_bus_if_i.dat_dev_oe), .xack_n(smp_bus_if_i.xack_n));
   wire [1:0] par_n = {smp_bus_if_i.parity_odd_byte_n, smp_bus_if_i.parity_even_byte_n};
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic report_and_stop();
      $display("samples_checked %0d miscompares %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // c = {inhibit, protect, timeout expected}; e[16] marks a read to compare
   task automatic op(input smp_pkg::smp_cmd_type k, input logic [23:0] ad, input logic odd,
      input logic [15:0] wd, input logic [2:0] c, input logic [16:0] e);
      int n;
      if (!c[0])
         exp_q.push_back(e);
      @(posedge ref_clk_i);
      req_i <= 1'b1;
      kind_i <= k;
      addr_i <= ad;
      odd_byte_i <= odd;
      wdata_i <= wd;
      inhibit_i <= c[2];
      protect_i <= c[1];
      @(posedge ref_clk_i);
      req_i <= 1'b0;
      `WAIT(ready_o, 3000)
      `CHK(timeout_o, c[0])
   endtask
   always @(posedge ref_clk_i) if (done_o && !timeout_o && exp_q.size() > 0) begin
      mon_e = exp_q.pop_front();
      if (mon_e[16])
         `CHK(rdata_o, mon_e[15:0])
   end
   initial begin
      {req_i, odd_byte_i, inhibit_i, protect_i, refresh_req_i, loc_req_i} = '0;
      kind_i = smp_pkg::SMP_MEM_RD;
      {loc_we_i, parity_enable_i} = 2'h3;
      {addr_i, wdata_i, io_in_i, loc_addr_i, loc_wdata_i} = '0;
      repeat (6) @(posedge ref_clk_i);
      arst_n_i <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         seed = lfsr(seed);
         a = {13'h0A5, seed[25:16], 1'b1};
         w = seed[15:0];
         op(smp_pkg::SMP_MEM_WR, a, 1'b1, w, 3'h0, 17'h0);
         op(smp_pkg::SMP_MEM_RD, a, 1'b1, 16'h0, 3'h0, {1'b1, w});
         `CHK(par_n, {^w[15:8], ^w[7:0]})
      end
      op(smp_pkg::SMP_MEM_RD, {a[23:1], 1'b0}, 1'b1, w, 3'h0, {1'b1, w[15:8], 8'h00});
      op(smp_pkg::SMP_MEM_RD, a, 1'b0, 16'h0, 3'h0, {1'b1, 8'h00, w[7:0]});
      @(posedge ref_clk_i) io_in_i <= seed[31:16];
      op(smp_pkg::SMP_IO_WR, 24'h000247, 1'b1, ~w, 3'h0, 17'h0);
      `CHK(io_port_o, ~w)
      op(smp_pkg::SMP_IO_RD, 24'h000247, 1'b1, 16'h0, 3'h0, {1'b1, seed[31:16]});
      op(smp_pkg::SMP_MEM_RD, a, 1'b1, 16'h0, 3'h5, 17'h0);
      op(smp_pkg::SMP_MEM_WR, a, 1'b1, 16'h0F0F, 3'h3, 17'h0);
      op(smp_pkg::SMP_MEM_RD, 24'h000001, 1'b1, 16'h0, 3'h1, 17'h0);
      op(smp_pkg::SMP_MEM_RD, a, 1'b1, 16'h0, 3'h0, {1'b1, w});
      @(posedge ref_clk_i);
      inhibit_i <= 1'b1;
      loc_req_i <= 1'b1;
      loc_addr_i <= ~a[10:1];
      loc_wdata_i <= seed[31:16];
      `WAIT(loc_ack_o, 50)
      @(posedge ref_clk_i) loc_we_i <= 1'b0;
      `WAIT(loc_ack_o, 50)
      `CHK(loc_rdata_o, seed[31:16])
      @(posedge ref_clk_i);
      loc_req_i <= 1'b0;
      op(smp_pkg::SMP_MEM_RD, {13'h0A5, ~a[10:1], 1'b1}, 1'b1, w, 3'h0,
         {1'b1, seed[31:16]});
      // the refresh request lands just before the command, which must wait for it
      fork
         op(smp_pkg::SMP_MEM_RD, a, 1'b1, w, 3'h0, {1'b1, w});
         begin
            repeat (11) @(posedge ref_clk_i);
            refresh_req_i <= 1'b1;
            @(posedge ref_clk_i) refresh_req_i <= 1'b0;
            `WAIT(refresh_busy_o, 50)
            `WAIT(!refresh_busy_o, 200)
            `CHK(n, 96)
         end
      join
      @(posedge ref_clk_i) parity_enable_i <= 1'b0;
      repeat (2) @(posedge ref_clk_i);
      `CHK(par_n, 2'h3)
      `CHK(exp_q.size(), 0)
      repeat (20) @(posedge ref_clk_i);
      report_and_stop();
   end
endmodule
`default_nettype wire
